// ---- hw/xoe_cyc.sv ----
`timescale 1ns/100ps
// system divider and instruction timer: counts an instruction's cycles in divider periods
module xoe_cyc #(
  parameter int CNT_W = 6
) (
  input  wire logic             hclk,      // system clock
  input  wire logic             hresetn,   // async reset, active low
  input  wire logic             fast_mode, // 1 selects divide-by-1
  input  wire logic             load,      // one-cycle start of an instruction
  input  wire logic [CNT_W-1:0] load_cnt,  // cycles the instruction takes
  output logic                  busy       // instruction still running
);
  generate
    if (CNT_W < xoe_pkg::CNT_W) begin : g_chk
      $error("xoe_cyc: CNT_W too small for the longest instruction");
    end
  endgenerate

  logic             div_q;
  logic             div_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire              tick;

  // divide-by-1 in fast mode, divide-by-2 in compatibility mode
  assign tick  = fast_mode ? 1'b1 : div_q;
  assign div_d = load ? 1'b0 : ~div_q; // phase restarts low so the first divided period is a whole one

  // count restarts on load so the first period is always whole
  assign cnt_d = load ? load_cnt :
                 (tick && cnt_q != '0) ? cnt_q - {{(CNT_W-1){1'b0}}, 1'b1} : cnt_q;

  // timer state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 1'b0;
      cnt_q <= '0;
      busy  <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      busy  <= (cnt_d != '0);
    end
  end
endmodule

// ---- hw/xoe_top.sv ----
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - first byte a5 is an escape; next byte decodes as an extended opcode.
// - arithmetic shift moves all forty bits right, bit 39 kept, flags untouched.
// - clear of the multiply-accumulate register zeroes forty bits, flags untouched.
// - breakpoint with debug unit on halts, pc already at the next instruction.
// - breakpoint with debug unit off is two nops: pc plus two, no flags.
// - escaped compare checks accumulator against indirect byte, branches if unequal.
// - branch target is advanced pc plus sign-extended last-byte displacement.
// - carry set when accumulator is below indirect byte unsigned, else cleared.
// - alternate increment adds one mod 65536 to the unselected pointer, no flags.
// - standard indirect-immediate compare b6/b7 is three bytes, 12 or 4 clocks.
// - escaped compare b6/b7 takes 18 compatibility clocks or 4 fast clocks.
// - timing counts divider periods; divider 1 in fast, 2 in compatibility mode.
// - external moves add 24 clocks in compatibility, one per wait state in fast.
// - select bit zero: plain uses pointer zero, alternate uses one; swapped otherwise.
module xoe_top (
  input  wire logic        hclk,      // system clock
  input  wire logic        hresetn,   // async reset, active low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic [2:0]  hsize,     // transfer size, word only
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic      [31:0] hrdata,    // read data
  output logic             hreadyout, // slave ready
  output logic             hresp,     // response, always okay
  output logic             debug_halt,// core parked in debug handler
  output logic             busy       // instruction timing in progress
);
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ESCAPED,
    ST_IMM,
    ST_REL
  } xoe_state_t;

  // bus data-phase state
  logic             dwr_q;
  logic [7:0]       daddr_q;
  // architectural and decoder state
  xoe_pkg::xoe_ctrl_t ctrl_q, ctrl_d;
  xoe_state_t       st_q, st_d;
  logic [7:0]       acc_q, acc_d;
  logic [7:0]       ind_q, ind_d;
  logic [15:0]      pc_q, pc_d;
  logic [15:0]      dpz_q, dpz_d;
  logic [15:0]      dpo_q, dpo_d;
  logic [39:0]      mac_q, mac_d;
  logic             carry_q, carry_d;
  logic             halt_q, halt_d;
  logic             badesc_q, badesc_d;
  logic             esc_q, esc_d;
  logic [7:0]       imm_q, imm_d;
  logic [7:0]       feed_q, feed_d;
  logic [xoe_pkg::CNT_W-1:0] lastcyc_q;
  logic             load;
  logic [xoe_pkg::CNT_W-1:0] load_cnt;
  logic             tmr_busy;

  // cycles for an instruction under the current mode
  function automatic logic [xoe_pkg::CNT_W-1:0] cyc(input logic fast, input int nf, input int nc);
    cyc = fast ? xoe_pkg::CNT_W'(nf) : xoe_pkg::CNT_W'(nc);
  endfunction

  // external move timing with wait states added
  function automatic logic [xoe_pkg::CNT_W-1:0] external_data_move_cyc(input logic fast, input logic [1:0] ws,
                                                           input int nf, input int nc);
    external_data_move_cyc = fast ? xoe_pkg::CNT_W'(nf) + xoe_pkg::CNT_W'(ws)
                    : xoe_pkg::CNT_W'(nc) + xoe_pkg::CNT_W'(xoe_pkg::CYC_EXTERNAL_DATA_MOVE_WS_COMP);
  endfunction

  // advanced pc plus signed displacement, modulo 2^16
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] rel);
    rel_target = pc + xoe_pkg::LEN_THREE + {{8{rel[7]}}, rel};
  endfunction

  // address-phase qualification and data-phase decode
  wire addr_ok  = hsel & hready & htrans[1];
  wire wr_en    = dwr_q;
  wire wr_ctrl  = wr_en && daddr_q == xoe_pkg::OFF_CTRL;
  wire wr_feed  = wr_en && daddr_q == xoe_pkg::OFF_FEED;
  wire wr_acc   = wr_en && daddr_q == xoe_pkg::OFF_ACCUM;
  wire wr_ind   = wr_en && daddr_q == xoe_pkg::OFF_IND;
  wire wr_pc    = wr_en && daddr_q == xoe_pkg::OFF_PC;
  wire wr_dpz   = wr_en && daddr_q == xoe_pkg::OFF_DPZ;
  wire wr_dpo   = wr_en && daddr_q == xoe_pkg::OFF_DPO;
  wire wr_maclo = wr_en && daddr_q == xoe_pkg::OFF_MAC_LO;
  wire wr_machi = wr_en && daddr_q == xoe_pkg::OFF_MAC_HI;
  wire wr_stat  = wr_en && daddr_q == xoe_pkg::OFF_STATUS;

  // a fed byte is taken only when the core is free and not parked
  wire byte_ok  = wr_feed && !tmr_busy && !halt_q;
  wire [7:0] fb = hwdata[7:0];

  // alternate pointer is the one the select bit does not name
  wire alt_is_one = ~ctrl_q.pointer_select_bit;

  // compare operands: escaped form is accumulator vs indirect, plain is indirect vs immediate
  wire [7:0] cmp_a   = esc_q ? acc_q : ind_q;
  wire [7:0] cmp_b   = esc_q ? ind_q : imm_q;
  wire       cmp_ne  = cmp_a != cmp_b;
  wire       cmp_lt  = cmp_a < cmp_b;

  // read mux
  wire [31:0] stat_word = {16'h0000, 2'b00, lastcyc_q, 4'h0, badesc_q, halt_q, carry_q, tmr_busy};
  wire [31:0] rd_mux =
    (haddr[7:0] == xoe_pkg::OFF_CTRL)   ? {24'h000000, 2'b00, ctrl_q.wait_states, 1'b0,
                                           ctrl_q.pointer_select_bit, ctrl_q.debug_unit,
                                           ctrl_q.fast_mode} :
    (haddr[7:0] == xoe_pkg::OFF_FEED)   ? {24'h000000, feed_q} :
    (haddr[7:0] == xoe_pkg::OFF_ACCUM)  ? {24'h000000, acc_q} :
    (haddr[7:0] == xoe_pkg::OFF_IND)    ? {24'h000000, ind_q} :
    (haddr[7:0] == xoe_pkg::OFF_PC)     ? {16'h0000, pc_q} :
    (haddr[7:0] == xoe_pkg::OFF_DPZ)    ? {16'h0000, dpz_q} :
    (haddr[7:0] == xoe_pkg::OFF_DPO)    ? {16'h0000, dpo_q} :
    (haddr[7:0] == xoe_pkg::OFF_MAC_LO) ? mac_q[31:0] :
    (haddr[7:0] == xoe_pkg::OFF_MAC_HI) ? {24'h000000, mac_q[39:32]} :
    (haddr[7:0] == xoe_pkg::OFF_STATUS) ? stat_word : 32'h00000000;

  // software writes first, then the decoder overrides what the instruction changes
  always_comb begin
    ctrl_d   = ctrl_q;
    st_d     = st_q;
    acc_d    = acc_q;
    ind_d    = ind_q;
    pc_d     = pc_q;
    dpz_d    = dpz_q;
    dpo_d    = dpo_q;
    mac_d    = mac_q;
    carry_d  = carry_q;
    halt_d   = halt_q;
    badesc_d = badesc_q;
    esc_d    = esc_q;
    imm_d    = imm_q;
    feed_d   = feed_q;
    load     = 1'b0;
    load_cnt = '0;

    if (wr_ctrl) begin
      ctrl_d.fast_mode          = hwdata[xoe_pkg::CTRL_FAST_BIT];
      ctrl_d.debug_unit         = hwdata[xoe_pkg::CTRL_DBG_BIT];
      ctrl_d.pointer_select_bit = hwdata[xoe_pkg::CTRL_PSEL_BIT];
      ctrl_d.wait_states        = hwdata[xoe_pkg::CTRL_WS_LSB +: xoe_pkg::CTRL_WS_W];
    end
    if (wr_acc)   acc_d = hwdata[7:0];
    if (wr_ind)   ind_d = hwdata[7:0];
    if (wr_pc)    pc_d  = hwdata[15:0];
    if (wr_dpz)   dpz_d = hwdata[15:0];
    if (wr_dpo)   dpo_d = hwdata[15:0];
    if (wr_maclo) mac_d[31:0]  = hwdata;
    if (wr_machi) mac_d[39:32] = hwdata[7:0];
    // write-one-to-clear of the sticky flags
    if (wr_stat && hwdata[xoe_pkg::STAT_HALT_BIT])   halt_d   = 1'b0;
    if (wr_stat && hwdata[xoe_pkg::STAT_BADESC_BIT]) badesc_d = 1'b0;

    if (byte_ok) begin
      feed_d = fb;
      case (st_q)
        ST_OPCODE: begin
          esc_d = 1'b0;
          if (fb == xoe_pkg::OP_ESCAPE) begin
            st_d  = ST_ESCAPED;
          end else if (fb[7:1] == xoe_pkg::OP_COMPARE_JUMP_UNEQUAL_IND) begin
            st_d  = ST_IMM;
          end else if (fb == xoe_pkg::OP_EXTERNAL_DATA_MOVE_RD || fb == xoe_pkg::OP_EXTERNAL_DATA_MOVE_WR) begin
            pc_d     = pc_q + xoe_pkg::LEN_ONE;
            load     = 1'b1;
            load_cnt = external_data_move_cyc(ctrl_q.fast_mode, ctrl_q.wait_states,
                                xoe_pkg::CYC_EXTERNAL_DATA_MOVE_FAST, xoe_pkg::CYC_EXTERNAL_DATA_MOVE_COMP);
          end else begin
            // other plain opcodes are not executed here, only stepped over
            pc_d     = pc_q + xoe_pkg::LEN_ONE;
            load     = 1'b1;
            load_cnt = cyc(1'b1, xoe_pkg::CYC_OTHER, xoe_pkg::CYC_OTHER);
          end
        end
        ST_ESCAPED: begin
          st_d = ST_OPCODE;
          load = 1'b1;
          if (fb == xoe_pkg::OP_SHIFT_RIGHT_ARITH_ACC) begin
            mac_d    = {mac_q[39], mac_q[39:1]};
            pc_d     = pc_q + xoe_pkg::LEN_TWO;
            load_cnt = cyc(1'b1, xoe_pkg::CYC_ASR, xoe_pkg::CYC_ASR);
          end else if (fb == xoe_pkg::OP_CLEAR_MAC_ACC) begin
            mac_d    = 40'h0000000000;
            pc_d     = pc_q + xoe_pkg::LEN_TWO;
            load_cnt = cyc(1'b1, xoe_pkg::CYC_CLR, xoe_pkg::CYC_CLR);
          end else if (fb == xoe_pkg::OP_BREAK) begin
            pc_d     = pc_q + xoe_pkg::LEN_TWO;
            halt_d   = halt_d | ctrl_q.debug_unit;
            load_cnt = cyc(1'b1, xoe_pkg::CYC_BREAK, xoe_pkg::CYC_BREAK);
          end else if (fb == xoe_pkg::OP_INC_ALT) begin
            if (alt_is_one) begin
              dpo_d = dpo_q + 16'h0001;
            end else begin
              dpz_d = dpz_q + 16'h0001;
            end
            pc_d     = pc_q + xoe_pkg::LEN_TWO;
            load_cnt = cyc(ctrl_q.fast_mode, xoe_pkg::CYC_INC_FAST, xoe_pkg::CYC_INC_COMP);
          end else if (fb[7:1] == xoe_pkg::OP_COMPARE_JUMP_UNEQUAL_IND) begin
            // displacement byte still to come, as in the plain form
            esc_d = 1'b1;
            st_d  = ST_REL;
            load  = 1'b0;
          end else if (fb == xoe_pkg::OP_EXTERNAL_DATA_MOVE_RD || fb == xoe_pkg::OP_EXTERNAL_DATA_MOVE_WR) begin
            pc_d     = pc_q + xoe_pkg::LEN_TWO;
            load_cnt = external_data_move_cyc(ctrl_q.fast_mode, ctrl_q.wait_states,
                                xoe_pkg::CYC_XMOVX_FAST, xoe_pkg::CYC_XMOVX_COMP);
          end else begin
            // reserved escape: flagged rather than run as a nop
            badesc_d = 1'b1;
            pc_d     = pc_q + xoe_pkg::LEN_TWO;
            load_cnt = cyc(1'b1, xoe_pkg::CYC_OTHER, xoe_pkg::CYC_OTHER);
          end
        end
        ST_IMM: begin
          imm_d = fb;
          st_d  = ST_REL;
        end
        ST_REL: begin
          st_d    = ST_OPCODE;
          carry_d = cmp_lt;
          pc_d    = cmp_ne ? rel_target(pc_q, fb) : pc_q + xoe_pkg::LEN_THREE;
          load    = 1'b1;
          load_cnt = esc_q ? cyc(ctrl_q.fast_mode, xoe_pkg::CYC_XCJ_FAST, xoe_pkg::CYC_XCJ_COMP)
                           : cyc(ctrl_q.fast_mode, xoe_pkg::CYC_SCJ_FAST, xoe_pkg::CYC_SCJ_COMP);
        end
        default: begin
          st_d = ST_OPCODE;
        end
      endcase
    end
  end

  // instruction timer, counted in divider periods
  xoe_cyc #(
    .CNT_W (xoe_pkg::CNT_W)
  ) u_cyc (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .fast_mode (ctrl_q.fast_mode),
    .load      (load),
    .load_cnt  (load_cnt),
    .busy      (tmr_busy)
  );

  // bus slave: zero-wait, read data captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwr_q     <= 1'b0;
      daddr_q   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dwr_q     <= addr_ok & hwrite;
      daddr_q   <= haddr[7:0];
      hrdata    <= (addr_ok && !hwrite) ? rd_mux : hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // architectural state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q   <= xoe_pkg::CTRL_RST;
      st_q     <= ST_OPCODE;
      acc_q    <= 8'h00;
      ind_q    <= 8'h00;
      pc_q     <= 16'h0000;
      dpz_q    <= 16'h0000;
      dpo_q    <= 16'h0000;
      mac_q    <= 40'h0000000000;
      carry_q  <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      st_q     <= st_d;
      acc_q    <= acc_d;
      ind_q    <= ind_d;
      pc_q     <= pc_d;
      dpz_q    <= dpz_d;
      dpo_q    <= dpo_d;
      mac_q    <= mac_d;
      carry_q  <= carry_d;
    end
  end

  // decoder scratch and flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_q     <= 1'b0;
      badesc_q   <= 1'b0;
      esc_q      <= 1'b0;
      imm_q      <= 8'h00;
      feed_q     <= 8'h00;
      lastcyc_q  <= '0;
      debug_halt <= 1'b0;
    end else begin
      halt_q     <= halt_d;
      badesc_q   <= badesc_d;
      esc_q      <= esc_d;
      imm_q      <= imm_d;
      feed_q     <= feed_d;
      lastcyc_q  <= load ? load_cnt : lastcyc_q;
      debug_halt <= halt_d;
    end
  end

  // busy from the timer's own flop
  assign busy = tmr_busy;
endmodule

// ---- pkg/xoe_pkg.sv ----
package xoe_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FEED   = 8'h04;
  localparam logic [7:0] OFF_ACCUM  = 8'h08;
  localparam logic [7:0] OFF_IND    = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_DPZ    = 8'h14;
  localparam logic [7:0] OFF_DPO    = 8'h18;
  localparam logic [7:0] OFF_MAC_LO = 8'h1c;
  localparam logic [7:0] OFF_MAC_HI = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;

  // control word fields
  localparam int CTRL_FAST_BIT = 0;
  localparam int CTRL_DBG_BIT  = 1;
  localparam int CTRL_PSEL_BIT = 2;
  localparam int CTRL_WS_LSB   = 4;
  localparam int CTRL_WS_W     = 2;

  // status word fields
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_CARRY_BIT  = 1;
  localparam int STAT_HALT_BIT   = 2;
  localparam int STAT_BADESC_BIT = 3;
  localparam int STAT_CYC_LSB    = 8;

  typedef struct packed {
    logic [1:0] wait_states;
    logic       pointer_select_bit;
    logic       debug_unit;
    logic       fast_mode;
  } xoe_ctrl_t;

  localparam xoe_ctrl_t CTRL_RST = '{wait_states: 2'h0, pointer_select_bit: 1'b0,
                                     debug_unit: 1'b0, fast_mode: 1'b1};

  // opcode bytes
  localparam logic [7:0] OP_ESCAPE   = 8'ha5;
  localparam logic [7:0] OP_SHIFT_RIGHT_ARITH_ACC    = 8'h03;
  localparam logic [7:0] OP_CLEAR_MAC_ACC    = 8'he4;
  localparam logic [7:0] OP_BREAK    = 8'h00;
  localparam logic [7:0] OP_INC_ALT  = 8'ha3;
  localparam logic [6:0] OP_COMPARE_JUMP_UNEQUAL_IND = 7'h5b;  // b6/b7 with the register bit dropped
  localparam logic [7:0] OP_EXTERNAL_DATA_MOVE_RD  = 8'he0;
  localparam logic [7:0] OP_EXTERNAL_DATA_MOVE_WR  = 8'hf0;

  // cycle counts in divider-output periods
  localparam int CNT_W          = 6;
  localparam int CYC_ASR        = 2;
  localparam int CYC_CLR        = 2;
  localparam int CYC_BREAK      = 2;
  localparam int CYC_INC_FAST   = 3;
  localparam int CYC_INC_COMP   = 18;
  localparam int CYC_XCJ_FAST   = 4;
  localparam int CYC_XCJ_COMP   = 18;
  localparam int CYC_SCJ_FAST   = 4;
  localparam int CYC_SCJ_COMP   = 12;
  localparam int CYC_EXTERNAL_DATA_MOVE_FAST  = 4;
  localparam int CYC_EXTERNAL_DATA_MOVE_COMP  = 12;
  localparam int CYC_XMOVX_FAST = 5;
  localparam int CYC_XMOVX_COMP = 18;
  localparam int CYC_EXTERNAL_DATA_MOVE_WS_COMP = 24;
  localparam int CYC_OTHER      = 1;

  // system divider ratios
  localparam int DIV_FAST = 1;
  localparam int DIV_COMP = 2;

  // pc advance per instruction length
  localparam logic [15:0] LEN_ONE   = 16'h0001;
  localparam logic [15:0] LEN_TWO   = 16'h0002;
  localparam logic [15:0] LEN_THREE = 16'h0003;
endpackage

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, debug_halt, busy;
  wire         hready = hreadyout;
  int          bad_count = 0;
  int          checks_done = 0;
  int          run = 0;
  int          blen = 0;
  logic [31:0] r;
  xoe_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .debug_halt, .busy);
  always #10 hclk = ~hclk;
  // length of the last busy run, in clock cycles
  always @(posedge hclk) begin
    if (busy === 1'b1) run <= run + 1;
    else begin
      if (run != 0) blen <= run;
      run <= 0;
    end
  end
  task results;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one single transfer; the trailing idle cycle keeps a following read from seeing old data
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0; hwdata <= d;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 40);
    r = hrdata;
    @(posedge hclk);
    if (n >= 40) begin bad_count++; results(); end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task exp_reg(input logic [7:0] a, input logic [31:0] e); bus(1'b0, a, 32'h0); chk(r, e); endtask
  task feed(input logic [7:0] b);
    int n;
    n = 0;
    wr(xoe_pkg::OFF_FEED, {24'h0, b});
    while (busy !== 1'b0 && n < 200) begin @(posedge hclk); n++; end
    if (n >= 200) begin bad_count++; results(); end
  endtask
  task exp_cyc(input int n, input int dv);
    bus(1'b0, xoe_pkg::OFF_STATUS, 32'h0);
    chk((r >> 8) & 32'h3f, n);
    chk(blen, n * dv);
  endtask
  task t_reset;
    exp_reg(xoe_pkg::OFF_CTRL, 32'h1);
    exp_reg(xoe_pkg::OFF_STATUS, 32'h0);
    wr(8'h3c, 32'hffffffff);
    exp_reg(8'h3c, 32'h0);
    $display("reset test done");
  endtask
  // escaped and plain compares, both speeds, branch forward, back and not at all
  task automatic t_cmp;
    logic [7:0] a [4] = '{8'h34, 8'h56, 8'h77, 8'h12};
    logic [7:0] b [4] = '{8'h56, 8'h34, 8'h77, 8'h80};
    logic [7:0] rl [4] = '{8'h10, 8'hf0, 8'h20, 8'h05};
    logic       es [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic       fm [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [15:0] pc;
    for (int i = 0; i < 4; i++) begin
      wr(xoe_pkg::OFF_CTRL, {31'h0, fm[i]});
      wr(xoe_pkg::OFF_PC, 32'h1000);
      wr(xoe_pkg::OFF_ACCUM, {24'h0, a[i]});
      wr(xoe_pkg::OFF_IND, es[i] ? {24'h0, b[i]} : {24'h0, a[i]});
      if (es[i]) feed(xoe_pkg::OP_ESCAPE);
      feed({7'h5b, i[0]});
      if (!es[i]) feed(b[i]);
      feed(rl[i]);
      pc = 16'h1003 + ((a[i] != b[i]) ? {{8{rl[i][7]}}, rl[i]} : 16'h0);
      exp_reg(xoe_pkg::OFF_PC, {16'h0, pc});
      exp_reg(xoe_pkg::OFF_ACCUM, {24'h0, a[i]});
      exp_reg(xoe_pkg::OFF_IND, es[i] ? {24'h0, b[i]} : {24'h0, a[i]});
      exp_cyc(es[i] ? (fm[i] ? 4 : 18) : (fm[i] ? 4 : 12), fm[i] ? 1 : 2);
      // r now holds the status word read by exp_cyc
      chk((r >> 1) & 32'h1, 32'(a[i] < b[i]));
      bus(1'b0, xoe_pkg::OFF_STATUS, 32'h0);
      chk((r >> 1) & 32'h1, 32'(a[i] < b[i]));
    end
    $display("compare test done");
  endtask
  // carry is left set by the last compare and must survive both
  task t_mac;
    wr(xoe_pkg::OFF_CTRL, 32'h1);
    wr(xoe_pkg::OFF_MAC_LO, 32'hb1a29384);
    wr(xoe_pkg::OFF_MAC_HI, 32'hc5);
    feed(xoe_pkg::OP_ESCAPE);
    feed(xoe_pkg::OP_SHIFT_RIGHT_ARITH_ACC);
    exp_reg(xoe_pkg::OFF_MAC_LO, 32'hd8d149c2);
    exp_reg(xoe_pkg::OFF_MAC_HI, 32'he2);
    exp_cyc(2, 1);
    chk((r >> 1) & 32'h1, 32'h1);
    feed(xoe_pkg::OP_ESCAPE);
    feed(xoe_pkg::OP_CLEAR_MAC_ACC);
    exp_reg(xoe_pkg::OFF_MAC_LO, 32'h0);
    exp_reg(xoe_pkg::OFF_MAC_HI, 32'h0);
    exp_cyc(2, 1);
    chk((r >> 1) & 32'h1, 32'h1);
    $display("mac test done");
  endtask
  task inc_alt; feed(xoe_pkg::OP_ESCAPE); feed(xoe_pkg::OP_INC_ALT); endtask
  task t_inc;
    wr(xoe_pkg::OFF_CTRL, 32'h1);
    wr(xoe_pkg::OFF_DPO, 32'h12fe);
    wr(xoe_pkg::OFF_DPZ, 32'h5555);
    repeat (3) inc_alt();
    exp_reg(xoe_pkg::OFF_DPO, 32'h1301);
    exp_reg(xoe_pkg::OFF_DPZ, 32'h5555);
    exp_cyc(3, 1);
    wr(xoe_pkg::OFF_CTRL, 32'h5);
    wr(xoe_pkg::OFF_DPZ, 32'hffff);
    inc_alt();
    exp_reg(xoe_pkg::OFF_DPZ, 32'h0);
    exp_reg(xoe_pkg::OFF_DPO, 32'h1301);
    wr(xoe_pkg::OFF_CTRL, 32'h0);
    inc_alt();
    exp_reg(xoe_pkg::OFF_DPO, 32'h1302);
    exp_cyc(18, 2);
    $display("pointer test done");
  endtask
  task t_break;
    wr(xoe_pkg::OFF_CTRL, 32'h1);
    wr(xoe_pkg::OFF_PC, 32'h20);
    feed(xoe_pkg::OP_ESCAPE);
    feed(xoe_pkg::OP_BREAK);
    exp_reg(xoe_pkg::OFF_PC, 32'h22);
    chk({31'h0, debug_halt}, 32'h0);
    wr(xoe_pkg::OFF_CTRL, 32'h3);
    feed(xoe_pkg::OP_ESCAPE);
    feed(xoe_pkg::OP_BREAK);
    chk({31'h0, debug_halt}, 32'h1);
    feed(8'h00);
    exp_reg(xoe_pkg::OFF_PC, 32'h24);
    wr(xoe_pkg::OFF_STATUS, 32'h4);
    chk({31'h0, debug_halt}, 32'h0);
    feed(xoe_pkg::OP_ESCAPE);
    feed(8'h55);
    exp_reg(xoe_pkg::OFF_PC, 32'h26);
    bus(1'b0, xoe_pkg::OFF_STATUS, 32'h0);
    chk((r >> 3) & 32'h1, 32'h1);
    wr(xoe_pkg::OFF_STATUS, 32'h8);
    $display("break test done");
  endtask
  // wait states in fast mode, fixed 24-period add in compatibility, plain and escaped moves
  task automatic t_external_data_move;
    logic [31:0] c [4] = '{32'h31, 32'h21, 32'h0, 32'h0};
    logic [7:0]  o [4] = '{8'he0, 8'hf0, 8'hf0, 8'he0};
    int          n [4] = '{7, 7, 36, 42};
    for (int i = 0; i < 4; i++) begin
      wr(xoe_pkg::OFF_CTRL, c[i]);
      if (i[0]) feed(xoe_pkg::OP_ESCAPE);
      feed(o[i]);
      exp_cyc(n[i], c[i][0] ? 1 : 2);
    end
    $display("move test done");
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_cmp();
    t_mac();
    t_inc();
    t_break();
    t_external_data_move();
    results();
  end
endmodule

// ---- sim/xoe_top_properties.sv ----
`timescale 1ns/100ps
// port-level checks; helper flops track bus phases and the speed mode
module xoe_top_properties (
  input wire logic        hclk,       // clock
  input wire logic        hresetn,    // reset, low
  input wire logic        hsel,       // select
  input wire logic [31:0] haddr,      // address
  input wire logic [1:0]  htrans,     // transfer type
  input wire logic        hwrite,     // write
  input wire logic [2:0]  hsize,      // size
  input wire logic [31:0] hwdata,     // write data
  input wire logic        hready,     // ready in
  input wire logic [31:0] hrdata,     // read data
  input wire logic        hreadyout,  // ready out
  input wire logic        hresp,      // response
  input wire logic        debug_halt, // parked
  input wire logic        busy        // timing runs
);
  logic       ap_wr_q;
  logic [7:0] ap_a_q;
  logic       fast_q;
  // data phase of a write, needed because hwdata lags its address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q <= 1'b0;
      ap_a_q  <= 8'h00;
      fast_q  <= 1'b1;
    end else begin
      ap_wr_q <= hsel && hready && htrans[1] && hwrite;
      ap_a_q  <= haddr[7:0];
      if (ap_wr_q && ap_a_q == xoe_pkg::OFF_CTRL) fast_q <= hwdata[xoe_pkg::CTRL_FAST_BIT];
    end
  end
  wire feed_dp = ap_wr_q && ap_a_q == xoe_pkg::OFF_FEED;
  wire clr_dp  = ap_wr_q && ap_a_q == xoe_pkg::OFF_STATUS && hwdata[xoe_pkg::STAT_HALT_BIT];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a breakpoint runs two periods, then the timer stops
  sequence brk_run;
    busy [*2] ##1 !busy;
  endsequence
  busy_start_a: assert property ($rose(busy) |-> $past(feed_dp) && !$past(debug_halt))
    else $error("busy started without an accepted byte");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:84] !busy)
    else $error("instruction timing too long");
  compat_min_a: assert property ($rose(busy) && !fast_q |-> busy [*2])
    else $error("compatibility timing not doubled");
  halt_start_a: assert property ($rose(debug_halt) |-> $rose(busy) && $past(feed_dp))
    else $error("halt without a breakpoint");
  halt_len_a: assert property ($rose(debug_halt) && fast_q |-> brk_run)
    else $error("breakpoint length wrong");
  halt_hold_a: assert property (debug_halt && !clr_dp |=> debug_halt)
    else $error("halt dropped on its own");
  halt_fall_a: assert property ($fell(debug_halt) |-> $past(clr_dp))
    else $error("halt cleared without write");
  okay_resp_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not okay");
endmodule
bind xoe_top xoe_top_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .debug_halt, .busy);
